// ===== logic/tsfs_blinker.sv
// Fault lamp blink generator: groups of 1..3 flashes then a pause.
// Assumes code is stable while faulted; slot length is a parameter.
module tsfs_blinker #(
  parameter int SLOT_CYC = tsfs_pkg::TSFS_FLASH_CYC
) (
  // Clock and reset
  input  wire logic               aclk,
  input  wire logic               aresetn,
  // Code in, lamp out
  input  wire tsfs_pkg::tsfs_fault_t code,
  output logic                    lamp
);
  import tsfs_pkg::*;
  initial if (SLOT_CYC < 1) $error("SLOT_CYC must be positive");
  logic [31:0] cnt_q;
  logic [3:0]  slot_q;
  logic [3:0]  flashes;
  // Even slots light for each flash, the rest stay dark as the pause
  assign flashes = {2'b00, code};
  // ----------------------------------------------------------------------
  // Slot counter
  // ----------------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn || code == TSFS_F_NONE) begin
      cnt_q  <= 32'h0;
      slot_q <= 4'h0;
      lamp   <= 1'b0;
    end else begin
      if (cnt_q == 32'(SLOT_CYC - 1)) begin
        cnt_q  <= 32'h0;
        slot_q <= (slot_q == 4'((2 * 3) + TSFS_PAUSE_SLOTS)) ? 4'h0 : slot_q + 4'h1;
      end else begin
        cnt_q <= cnt_q + 32'h1;
      end
      lamp <= !slot_q[0] && (slot_q[3:1] < flashes[2:0]);
    end
  end
endmodule : tsfs_blinker

// ===== logic/tsfs_pkg.sv
// Constants, register map and types of the setpoint and fault supervisor.
// Assumes one 50 MHz clock and digitised analog values arriving as inputs.
// Operation
// - Default limits give setpoint = voltage*60 - 100 degrees, linear.
// - With limits set, software picks clipping or slope transformation mode.
// - Clipping mode uses basic line, saturating at min and max limits.
// - Slope mode maps 0 V to min and 5 V to max linearly.
// - Each digital input has selectable active level, default low active.
// - Each digital output has selectable active level, default high active.
// - Each output selects push-pull or open-collector, push-pull after reset.
// - Any fault latches at once, stops regulation, zeroes current, drops ready.
// - While faulted every enable request is ignored.
// - Fault lamp blinks groups: one sensor, two short, three overtemperature.
// - Clear by dropping run input, then raising fault clear input.
// - A host reset command also clears latched faults.
// - Sensor signal outside working range raises a sensor fault.
// - Power stage above 80 degrees raises an overtemperature fault.
// - Overtemperature clears only below 75 degrees, else stays latched.
// - Short-circuit detector trips the fault with no software latency.
// - Sensor fault below 0.08 V or above 2.35 V difference.
package tsfs_pkg;
  // ----------------------------------------------------------------------
  // Register map (byte addresses)
  // ----------------------------------------------------------------------
  localparam logic [7:0] TSFS_OFS_CTRL    = 8'h00; // Mode, limits enable, run, cmd
  localparam logic [7:0] TSFS_OFS_LIMITS  = 8'h04; // Min [15:0], max [31:16]
  localparam logic [7:0] TSFS_OFS_IOCFG   = 8'h08; // Polarity and stage bits
  localparam logic [7:0] TSFS_OFS_STATUS  = 8'h0C; // Faults, ready, first fault
  localparam logic [7:0] TSFS_OFS_SETPT   = 8'h10; // Computed setpoint
  // CTRL fields
  localparam int TSFS_CTRL_MODE_BIT   = 0;  // 0 clipping, 1 slope
  localparam int TSFS_CTRL_LIMEN_BIT  = 1;  // Limits configured
  localparam int TSFS_CTRL_SWRUN_BIT  = 2;  // Software enable request
  localparam int TSFS_CTRL_CLRCMD_BIT = 3;  // Write 1: host fault reset
  // IOCFG fields
  localparam int TSFS_IO_IN_POL_LSB   = 0;  // Input polarity, 1 high active
  localparam int TSFS_IO_OUT_POL_LSB  = 8;  // Output polarity, 1 high active
  localparam int TSFS_IO_OUT_OC_LSB   = 16; // Output stage, 1 open collector
  // ----------------------------------------------------------------------
  // Numeric scales: voltages in mV, temperatures in tenths of a degree
  // ----------------------------------------------------------------------
  localparam int TSFS_SLOPE_BASIC      = 60;    // Degrees per volt
  localparam int TSFS_OFFSET_BASIC     = -100;  // Degrees at 0 V
  localparam int TSFS_VFULL_MV         = 5000;  // Full input range
  localparam logic signed [15:0] TSFS_MIN_RST = -16'sd1000; // -100.0 C
  localparam logic signed [15:0] TSFS_MAX_RST = 16'sd2000;  // +200.0 C
  localparam logic signed [15:0] TSFS_OT_TRIP = 16'sd800;   // 80.0 C
  localparam logic signed [15:0] TSFS_OT_CLR  = 16'sd750;   // 75.0 C
  localparam logic [11:0] TSFS_SENS_LO_MV = 12'd80;         // 0.08 V
  localparam logic [11:0] TSFS_SENS_HI_MV = 12'd2350;       // 2.35 V
  localparam logic [31:0] TSFS_IOCFG_RST  = 32'h0000_FF00;  // In low, out high, pp
  // ----------------------------------------------------------------------
  // Blink timing
  // ----------------------------------------------------------------------
  localparam int TSFS_CLK_HZ       = 50_000_000;
  localparam int TSFS_FLASH_MS     = 200;
  localparam int TSFS_FLASH_CYC    = TSFS_CLK_HZ / 1000 * TSFS_FLASH_MS;
  localparam int TSFS_PAUSE_SLOTS  = 5; // Pause after the six flash slots lasts this plus one slots
  typedef enum logic [1:0] {TSFS_F_NONE, TSFS_F_SENS, TSFS_F_SHORT, TSFS_F_OT} tsfs_fault_t;
endpackage : tsfs_pkg

// ===== logic/tsfs_supervisor.sv
// Setpoint mapping, I/O polarity and latched fault supervisor, AXI4-Lite slave.
// Assumes digitised voltages and temperatures arrive synchronous to aclk.
module tsfs_supervisor #(
  parameter int NUM_IN    = 4,
  parameter int NUM_OUT   = 4,
  parameter int BLINK_CYC = tsfs_pkg::TSFS_FLASH_CYC
) (
  // Clock and reset
  input  wire logic                 aclk,
  input  wire logic                 aresetn,
  // AXI4-Lite write channels
  input  wire logic [7:0]           s_axil_awaddr,
  input  wire logic                 s_axil_awvalid,
  output logic                      s_axil_awready,
  input  wire logic [31:0]          s_axil_wdata,
  input  wire logic [3:0]           s_axil_wstrb,
  input  wire logic                 s_axil_wvalid,
  output logic                      s_axil_wready,
  output logic [1:0]                s_axil_bresp,
  output logic                      s_axil_bvalid,
  input  wire logic                 s_axil_bready,
  // AXI4-Lite read channels
  input  wire logic [7:0]           s_axil_araddr,
  input  wire logic                 s_axil_arvalid,
  output logic                      s_axil_arready,
  output logic [31:0]               s_axil_rdata,
  output logic [1:0]                s_axil_rresp,
  output logic                      s_axil_rvalid,
  input  wire logic                 s_axil_rready,
  // Analog measurements (mV, tenths of a degree)
  input  wire logic [12:0]          setpoint_voltage_input,
  input  wire logic [11:0]          sensor_diff_mv,
  input  wire logic signed [15:0]   stage_temp,
  input  wire logic                 short_trip,
  // Digital pins (raw levels)
  input  wire logic [NUM_IN-1:0]    din_pin,
  output logic [NUM_IN-1:0]         din_pull_up,
  input  wire logic [NUM_OUT-1:0]   dout_active,
  output logic [NUM_OUT-1:0]        dout_pin_o,
  output logic [NUM_OUT-1:0]        dout_pin_oe,
  // Control and status
  output logic [NUM_IN-1:0]         din_active,
  output logic signed [15:0]        setpoint_temp,
  output logic                      regulation_enable,
  output logic                      output_zero,
  output logic                      ready,
  output logic                      fault_indicator_lamp
);
  import tsfs_pkg::*;
  initial if (NUM_IN < 2 || NUM_IN > 8 || NUM_OUT < 1 || NUM_OUT > 8)
    $error("NUM_IN must be 2..8 and NUM_OUT 1..8");
  // din_active[0] is the run input, din_active[1] the fault clear input
  logic hardware_run_input;
  logic hardware_fault_clear_input;

  // ----------------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------------
  logic        setpoint_limit_mode_q, lim_en_q, sw_run_q, host_clr_q;
  logic signed [15:0] min_q, max_q;
  logic [31:0] iocfg_q;
  logic        f_sens_q, f_short_q, f_ot_q;
  tsfs_fault_t first_q;
  logic        clr_prev_q;
  logic        aw_hold_q, w_hold_q;
  logic [7:0]  aw_addr_q;
  logic [31:0] w_data_q;
  logic [3:0]  w_strb_q;

  // Byte-enable merge, used by the LIMITS and IOCFG registers
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) if (be[i]) r[8*i +: 8] = nw[8*i +: 8];
    return r;
  endfunction : merge

  // ----------------------------------------------------------------------
  // AXI4-Lite write path: address and data taken in any order
  // ----------------------------------------------------------------------
  logic do_write;
  assign s_axil_awready = !aw_hold_q && !s_axil_bvalid;
  assign s_axil_wready  = !w_hold_q && !s_axil_bvalid;
  assign do_write       = aw_hold_q && w_hold_q && !s_axil_bvalid;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_hold_q <= 1'b0;
      w_hold_q  <= 1'b0;
      aw_addr_q <= 8'h00;
      w_data_q  <= 32'h0;
      w_strb_q  <= 4'h0;
      s_axil_bvalid <= 1'b0;
      s_axil_bresp  <= 2'b00;
    end else begin
      if (s_axil_awvalid && s_axil_awready) begin
        aw_hold_q <= 1'b1;
        aw_addr_q <= s_axil_awaddr;
      end
      if (s_axil_wvalid && s_axil_wready) begin
        w_hold_q <= 1'b1;
        w_data_q <= s_axil_wdata;
        w_strb_q <= s_axil_wstrb;
      end
      if (do_write) begin
        aw_hold_q <= 1'b0;
        w_hold_q  <= 1'b0;
        s_axil_bvalid <= 1'b1;
        s_axil_bresp  <= (aw_addr_q == TSFS_OFS_CTRL || aw_addr_q == TSFS_OFS_LIMITS ||
                          aw_addr_q == TSFS_OFS_IOCFG) ? 2'b00 : 2'b10;
      end else if (s_axil_bvalid && s_axil_bready) begin
        s_axil_bvalid <= 1'b0;
      end
    end
  end

  // Configuration registers; host clear command is a one-cycle pulse
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      setpoint_limit_mode_q <= 1'b0;
      lim_en_q   <= 1'b0;
      sw_run_q   <= 1'b0;
      host_clr_q <= 1'b0;
      min_q      <= TSFS_MIN_RST;
      max_q      <= TSFS_MAX_RST;
      iocfg_q    <= TSFS_IOCFG_RST;
    end else begin
      host_clr_q <= 1'b0;
      if (do_write && aw_addr_q == TSFS_OFS_CTRL && w_strb_q[0]) begin
        setpoint_limit_mode_q <= w_data_q[TSFS_CTRL_MODE_BIT];
        lim_en_q   <= w_data_q[TSFS_CTRL_LIMEN_BIT];
        sw_run_q   <= w_data_q[TSFS_CTRL_SWRUN_BIT];
        host_clr_q <= w_data_q[TSFS_CTRL_CLRCMD_BIT];
      end
      if (do_write && aw_addr_q == TSFS_OFS_LIMITS) begin
        {max_q, min_q} <= merge({max_q, min_q}, w_data_q, w_strb_q);
      end
      if (do_write && aw_addr_q == TSFS_OFS_IOCFG) begin
        iocfg_q <= merge(iocfg_q, w_data_q, w_strb_q);
      end
    end
  end

  // ----------------------------------------------------------------------
  // Digital input and output polarity and stage type
  // ----------------------------------------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < NUM_IN; gi++) begin : g_in
      // Pull toward the inactive level so an open pin reads inactive
      assign din_active[gi]  = din_pin[gi] ~^ iocfg_q[TSFS_IO_IN_POL_LSB + gi];
      assign din_pull_up[gi] = !iocfg_q[TSFS_IO_IN_POL_LSB + gi];
    end
    for (gi = 0; gi < NUM_OUT; gi++) begin : g_out
      logic lvl;
      assign lvl = dout_active[gi] ~^ iocfg_q[TSFS_IO_OUT_POL_LSB + gi];
      // Open collector only sinks: drive low, release for high
      assign dout_pin_o[gi]  = iocfg_q[TSFS_IO_OUT_OC_LSB + gi] ? 1'b0 : lvl;
      assign dout_pin_oe[gi] = iocfg_q[TSFS_IO_OUT_OC_LSB + gi] ? !lvl : 1'b1;
    end
  endgenerate
  assign hardware_run_input         = din_active[0];
  assign hardware_fault_clear_input = din_active[1];

  // ----------------------------------------------------------------------
  // Setpoint mapping (tenths of a degree)
  // ----------------------------------------------------------------------
  logic signed [31:0] basic_t, slope_t, sp_d;
  always_comb begin
    // mV * 60 / 100 gives tenths; offset scaled by ten
    basic_t = (32'(signed'({1'b0, setpoint_voltage_input})) * TSFS_SLOPE_BASIC) / 100
              + TSFS_OFFSET_BASIC * 10;
    slope_t = ((32'(max_q) - 32'(min_q)) * 32'(signed'({1'b0, setpoint_voltage_input})))
              / TSFS_VFULL_MV + 32'(min_q);
    if (!lim_en_q) begin
      sp_d = basic_t;
    end else if (setpoint_limit_mode_q) begin
      sp_d = slope_t;
    end else if (basic_t < 32'(min_q)) begin
      sp_d = 32'(min_q);
    end else if (basic_t > 32'(max_q)) begin
      sp_d = 32'(max_q);
    end else begin
      sp_d = basic_t;
    end
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) setpoint_temp <= 16'sh0000;
    else          setpoint_temp <= sp_d[15:0];
  end

  // ----------------------------------------------------------------------
  // Fault detection and latching; set wins over clear
  // ----------------------------------------------------------------------
  logic det_sens, det_ot, clr_req, any_fault;
  assign det_sens  = sensor_diff_mv < TSFS_SENS_LO_MV ||
                     sensor_diff_mv > TSFS_SENS_HI_MV;
  assign det_ot    = stage_temp > TSFS_OT_TRIP;
  // Clear edge only counts while run input is already dropped
  assign clr_req   = (hardware_fault_clear_input && !clr_prev_q && !hardware_run_input)
                     || host_clr_q;
  assign any_fault = f_sens_q || f_short_q || f_ot_q;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      f_sens_q   <= 1'b0;
      f_short_q  <= 1'b0;
      f_ot_q     <= 1'b0;
      clr_prev_q <= 1'b0;
    end else begin
      clr_prev_q <= hardware_fault_clear_input;
      f_sens_q   <= det_sens || (f_sens_q && !clr_req);
      f_short_q  <= short_trip || (f_short_q && !clr_req);
      f_ot_q     <= det_ot || (f_ot_q && !(clr_req && stage_temp < TSFS_OT_CLR));
    end
  end
  // First fault recorded for the lamp; sensor wins a tie
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      first_q <= TSFS_F_NONE;
    end else if (!any_fault) begin
      first_q <= det_sens ? TSFS_F_SENS : short_trip ? TSFS_F_SHORT :
                 det_ot ? TSFS_F_OT : TSFS_F_NONE;
    end else if (!(f_sens_q || det_sens) && !(f_short_q || short_trip) &&
                 !(f_ot_q || det_ot)) begin
      first_q <= TSFS_F_NONE;
    end
  end
  // Only output_zero acts on raw detection; ready and regulation_enable follow the latched faults a cycle later
  assign regulation_enable = !any_fault && hardware_run_input && sw_run_q;
  assign output_zero       = any_fault || det_sens || short_trip || det_ot;
  assign ready             = !any_fault;

  tsfs_blinker #(.SLOT_CYC(BLINK_CYC)) u_blink (
    .aclk    (aclk),
    .aresetn (aresetn),
    .code    (first_q),
    .lamp    (fault_indicator_lamp)
  );

  // ----------------------------------------------------------------------
  // AXI4-Lite read path
  // ----------------------------------------------------------------------
  assign s_axil_arready = !s_axil_rvalid;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axil_rvalid <= 1'b0;
      s_axil_rdata  <= 32'h0;
      s_axil_rresp  <= 2'b00;
    end else if (s_axil_arvalid && s_axil_arready) begin
      s_axil_rvalid <= 1'b1;
      s_axil_rresp  <= 2'b00;
      case (s_axil_araddr)
        TSFS_OFS_CTRL:   s_axil_rdata <= {29'h0, sw_run_q, lim_en_q, setpoint_limit_mode_q};
        TSFS_OFS_LIMITS: s_axil_rdata <= {max_q, min_q};
        TSFS_OFS_IOCFG:  s_axil_rdata <= iocfg_q;
        TSFS_OFS_STATUS: s_axil_rdata <= {25'h0, first_q, ready, regulation_enable,
                                          f_ot_q, f_short_q, f_sens_q};
        TSFS_OFS_SETPT:  s_axil_rdata <= {{16{setpoint_temp[15]}}, setpoint_temp};
        default: begin
          s_axil_rdata <= 32'h0;
          s_axil_rresp <= 2'b10;
        end
      endcase
    end else if (s_axil_rvalid && s_axil_rready) begin
      s_axil_rvalid <= 1'b0;
    end
  end

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  property p_trip_latch;
    @(posedge aclk) disable iff (!aresetn) det_sens |=> f_sens_q && !ready;
  endproperty
  a_trip_latch: assert property (p_trip_latch) else $error("sensor fault not latched");
  property p_ignore_run;
    @(posedge aclk) disable iff (!aresetn) any_fault |-> !regulation_enable;
  endproperty
  a_ignore_run: assert property (p_ignore_run) else $error("enabled while faulted");
  property p_short_zero;
    @(posedge aclk) disable iff (!aresetn) short_trip |-> output_zero ##1 f_short_q;
  endproperty
  a_short_zero: assert property (p_short_zero) else $error("short trip slow");
  property p_ot_hold;
    @(posedge aclk) disable iff (!aresetn)
      f_ot_q && stage_temp >= TSFS_OT_CLR |=> f_ot_q;
  endproperty
  a_ot_hold: assert property (p_ot_hold) else $error("overtemp cleared while hot");
  property p_ot_trip;
    @(posedge aclk) disable iff (!aresetn) stage_temp > TSFS_OT_TRIP |=> f_ot_q;
  endproperty
  a_ot_trip: assert property (p_ot_trip) else $error("overtemp missed");
  property p_hw_clear;
    @(posedge aclk) disable iff (!aresetn)
      f_sens_q && !det_sens && !short_trip && !det_ot && !f_ot_q && !f_short_q
      && hardware_fault_clear_input && !clr_prev_q && !hardware_run_input |=> ready;
  endproperty
  a_hw_clear: assert property (p_hw_clear) else $error("clear not honoured");
  property p_clear_needs_stop;
    @(posedge aclk) disable iff (!aresetn)
      any_fault && hardware_run_input && !host_clr_q |=> any_fault;
  endproperty
  a_clear_needs_stop: assert property (p_clear_needs_stop) else $error("cleared while run");
  property p_host_clear;
    @(posedge aclk) disable iff (!aresetn)
      host_clr_q && !det_sens && !short_trip && !det_ot && !f_ot_q |=> !f_sens_q && !f_short_q;
  endproperty
  a_host_clear: assert property (p_host_clear) else $error("host clear ignored");
  property p_basic_map;
    @(posedge aclk) disable iff (!aresetn)
      !lim_en_q && $stable(setpoint_voltage_input) && setpoint_voltage_input == 13'd2500
      |=> setpoint_temp == 16'sd500;
  endproperty
  a_basic_map: assert property (p_basic_map) else $error("basic map wrong at 2.5 V");
  property p_clip;
    @(posedge aclk) disable iff (!aresetn)
      lim_en_q && !setpoint_limit_mode_q && basic_t > 32'(max_q) |=> setpoint_temp <= $past(max_q);
  endproperty
  a_clip: assert property (p_clip) else $error("clip exceeded max");
  property p_tie_sensor;
    @(posedge aclk) disable iff (!aresetn) !any_fault && det_sens |=> first_q == TSFS_F_SENS;
  endproperty
  a_tie_sensor: assert property (p_tie_sensor) else $error("wrong first fault");
  c_sens:  cover property (@(posedge aclk) disable iff (!aresetn) $rose(f_sens_q));
  c_clear: cover property (@(posedge aclk) disable iff (!aresetn) $fell(any_fault));
  c_slope: cover property (@(posedge aclk) disable iff (!aresetn)
                           lim_en_q && setpoint_limit_mode_q);
endmodule : tsfs_supervisor

// ===== verification/tsfs_ext_ctrl.sv
// External control circuit model: drives the raw run and clear pins.
// Assumes the supervisor's pull selection tells the active level of each pin.
module tsfs_ext_ctrl (
  // Logical requests
  input  wire logic       run,
  input  wire logic       clr,
  // Pin side
  input  wire logic [3:0] din_pull_up,
  output logic      [3:0] din_pin
);
  timeunit 1ns;
  timeprecision 1ps;
  // -----------------------------------------------------------
  // Pin drive
  // -----------------------------------------------------------
  // Pull-up means low active; idle pins rest at the pull level
  assign din_pin = {din_pull_up[3:2], din_pull_up[1] ^ clr, din_pull_up[0] ^ run};
endmodule : tsfs_ext_ctrl

// ===== verification/tsfs_supervisor_test.sv
// Self-checking bench of the supervisor: bus tasks and scenario calls.
// Assumes a 50 MHz clock and the 4-cycle blink slot set below.
module tsfs_supervisor_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic aclk = 0, aresetn = 0;
  logic [7:0] s_axil_awaddr = 0, s_axil_araddr = 0;
  logic s_axil_awvalid = 0, s_axil_wvalid = 0, s_axil_bready = 0;
  logic s_axil_arvalid = 0, s_axil_rready = 0;
  logic [31:0] s_axil_wdata = 0, s_axil_rdata;
  logic [3:0] s_axil_wstrb = 4'hF, din_pin, din_pull_up, din_active;
  logic [3:0] dout_active = 0, dout_pin_o, dout_pin_oe;
  logic s_axil_awready, s_axil_wready, s_axil_bvalid, s_axil_arready, s_axil_rvalid;
  logic [1:0] s_axil_bresp, s_axil_rresp;
  logic [12:0] setpoint_voltage_input = 13'd2500;
  logic [11:0] sensor_diff_mv = 12'd1000;
  logic signed [15:0] stage_temp = 16'sd300, setpoint_temp;
  logic short_trip = 0, run = 1, clr = 0;
  logic regulation_enable, output_zero, ready, fault_indicator_lamp;
  logic [31:0] d;
  logic [1:0] r;
  int mismatches = 0, num_checks = 0, n;
  tsfs_supervisor #(.BLINK_CYC(4)) tsfs_supervisor_i (.*);
  tsfs_ext_ctrl tsfs_ext_ctrl_i (.run(run), .clr(clr), .din_pull_up(din_pull_up),
    .din_pin(din_pin));
  always #10 aclk = ~aclk;
  // -----------------------------------------------------------
  // Tasks
  // -----------------------------------------------------------
  task stop_test;
    if (mismatches == 0 && num_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : stop_test
  task chk(input string nm, input logic [31:0] s, input logic [31:0] e);
    num_checks++;
    if (s !== e) begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", nm, e, s);
    end
  endtask : chk
  // Address and data are offered together, each released at the edge that takes it;
  // ready is read just after the edge, before the slave's registers move
  task wr(input logic [7:0] a, input logic [31:0] v);
    logic aw_ok, w_ok;
    aw_ok = 0;
    w_ok = 0;
    s_axil_awaddr <= a; s_axil_wdata <= v; s_axil_awvalid <= 1; s_axil_wvalid <= 1;
    while (!(aw_ok && w_ok)) begin
      @(posedge aclk);
      if (!aw_ok && s_axil_awready) begin
        aw_ok = 1;
        s_axil_awvalid <= 0;
      end
      if (!w_ok && s_axil_wready) begin
        w_ok = 1;
        s_axil_wvalid <= 0;
      end
    end
    s_axil_bready <= 1;
    do @(posedge aclk); while (!s_axil_bvalid);
    r = s_axil_bresp;
    s_axil_bready <= 0;
  endtask : wr
  task rd(input logic [7:0] a);
    s_axil_araddr <= a; s_axil_arvalid <= 1;
    do @(posedge aclk); while (!s_axil_arready);
    s_axil_arvalid <= 0; s_axil_rready <= 1;
    do @(posedge aclk); while (!s_axil_rvalid);
    d = s_axil_rdata; r = s_axil_rresp;
    s_axil_rready <= 0;
  endtask : rd
  // Setpoint is registered, so let it settle before looking
  task sp(input logic [12:0] v, input int e);
    setpoint_voltage_input <= v;
    repeat (3) @(posedge aclk);
    chk("setpoint", setpoint_temp, e);
  endtask : sp
  task settle;
    repeat (3) @(posedge aclk);
  endtask : settle
  // One blink period is 12 slots of 4 cycles: count lamp rising edges over it
  task blink(input logic [31:0] e);
    logic prev;
    n = 0;
    prev = fault_indicator_lamp;
    repeat (48) begin
      @(posedge aclk); #1;
      if (fault_indicator_lamp && !prev) n++;
      prev = fault_indicator_lamp;
    end
    chk("flashes", n, e);
  endtask : blink
  // -----------------------------------------------------------
  // Watchdog: the whole sequence needs well under 2000 cycles
  // -----------------------------------------------------------
  initial begin
    #100000;
    mismatches++;
    stop_test();
  end
  // -----------------------------------------------------------
  // Scenarios
  // -----------------------------------------------------------
  initial begin
    repeat (12) @(posedge aclk);
    aresetn <= 1;
    settle();
    rd(8'h08); chk("iocfg", d, 32'h0000FF00);
    chk("pull", din_pull_up, 4'hF);
    chk("dout", {dout_pin_oe, dout_pin_o}, 8'hF0);
    dout_active <= 4'h1; settle();
    chk("dout", {dout_pin_oe, dout_pin_o}, 8'hF1);
    rd(8'h04); chk("limits", d, 32'h07D0FC18);
    rd(8'h20); chk("rresp", r, 2'b10);
    wr(8'h0C, 32'h0); chk("bresp", r, 2'b10);
    sp(2500, 500); sp(0, -1000); sp(5000, 2000);
    wr(8'h08, 32'h0000FF0F); settle();
    chk("din", {din_pull_up, din_active[0]}, 5'h01);
    wr(8'h08, 32'h000FFF00); settle();
    chk("oc", {dout_pin_oe, dout_pin_o}, 8'hE0);
    wr(8'h04, 32'h032000C8); wr(8'h00, 32'h6);
    chk("bresp", r, 2'b00);
    sp(1000, 200); sp(4000, 800); sp(2500, 500);
    wr(8'h00, 32'h7);
    sp(1000, 320); sp(0, 200); sp(5000, 800);
    chk("regen", regulation_enable, 1);
    sensor_diff_mv <= 12'd79; settle();
    chk("flt", {ready, output_zero, regulation_enable}, 3'b010);
    sensor_diff_mv <= 12'd1000; settle();
    chk("latched", regulation_enable, 0);
    blink(1);
    clr <= 1; settle(); clr <= 0; settle();
    chk("runclr", ready, 0);
    run <= 0; settle(); clr <= 1; settle(); clr <= 0;
    chk("pinclr", ready, 1);
    sensor_diff_mv <= 12'd2351; settle(); sensor_diff_mv <= 12'd1000;
    rd(8'h0C); chk("status", d[6:0], 7'h21);
    wr(8'h00, 32'hF); settle(); chk("hostclr", ready, 1);
    stage_temp <= 16'sd801; settle(); stage_temp <= 16'sd760;
    clr <= 1; settle(); clr <= 0;
    chk("otkeep", ready, 0);
    blink(3);
    rd(8'h0C); chk("ot", d[2], 1);
    stage_temp <= 16'sd740; wr(8'h00, 32'hF); settle();
    chk("otclr", ready, 1);
    short_trip <= 1; #1;
    chk("short", output_zero, 1);
    settle();
    blink(2);
    short_trip <= 0; wr(8'h00, 32'hF); settle();
    run <= 1; settle();
    chk("rerun", regulation_enable, 1);
    stop_test();
  end
endmodule : tsfs_supervisor_test
